// ===== wdpc_pkg.sv
package wdpc_pkg;

  // ****************************************************
  // clock and timing
  // ****************************************************
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  // nominal watchdog period with no postscaler
  localparam int unsigned WDT_PERIOD_MS = 18;
  localparam int unsigned WDT_BASE_CYCLES = WDT_PERIOD_MS * (CLK_HZ / MS_PER_S);
  // hold-in-reset time, rounded up to whole cycles
  localparam int unsigned DRT_PERIOD_MS = 18;
  localparam int unsigned DRT_CYCLES =
    (DRT_PERIOD_MS * CLK_HZ + MS_PER_S - 1) / MS_PER_S;

  // ****************************************************
  // widths
  // ****************************************************
  localparam int unsigned CFG_W   = 12;
  localparam int unsigned OPT_W   = 6;
  localparam int unsigned PS_W    = 3;
  localparam int unsigned PRESC_W = 8;

  // ****************************************************
  // configuration word fields
  // ****************************************************
  localparam int unsigned CFG_OSC_LSB    = 0;
  localparam int unsigned CFG_WDT_EN_BIT = 2;
  localparam int unsigned CFG_CP_LSB     = 3;
  localparam int unsigned CFG_CP_MSB     = 11;
  // single-protect variant keeps only this protect bit
  localparam logic [CFG_W-1:0] CFG_SINGLE_MASK = 12'h00f;

  // ****************************************************
  // option setting fields
  // ****************************************************
  localparam int unsigned OPT_PS_LSB   = 0;
  localparam int unsigned OPT_PSA_BIT  = 3;
  localparam int unsigned OPT_EDGE_BIT = 4;
  localparam int unsigned OPT_SRC_BIT  = 5;
  localparam logic [OPT_W-1:0] OPTION_RESET = 6'h3f;
  // ratio field all ones, used as intermediate step
  localparam logic [PS_W-1:0] PS_ALL_ONES  = 3'h7;
  // final ratios at or below this need the intermediate step
  localparam logic [PS_W-1:0] PS_STEP_MAX  = 3'h1;

  // ****************************************************
  // enumerations
  // ****************************************************
  typedef enum logic [1:0] {
    low_power_crystal_mode  = 2'h0,
    standard_crystal_mode   = 2'h1,
    high_speed_crystal_mode = 2'h2,
    rc_oscillator_mode      = 2'h3
  } wdpc_osc_type;

  typedef enum logic [1:0] {
    CMD_CLEAR_WATCHDOG = 2'h0,
    CMD_TIMER_WRITE    = 2'h1,
    CMD_OPTION_WRITE   = 2'h2,
    CMD_SLEEP          = 2'h3
  } wdpc_cmd_type;

  typedef enum logic [9:0] {
    ST_IDLE   = 10'h001,
    ST_CLR    = 10'h002,
    ST_TMR    = 10'h004,
    ST_OPT    = 10'h008,
    ST_SLP    = 10'h010,
    ST_W_CLR  = 10'h020,
    ST_W_TMR  = 10'h040,
    ST_W_INT  = 10'h080,
    ST_W_CLR2 = 10'h100,
    ST_T_CLR  = 10'h200
  } wdpc_core_state_type;

endpackage

// ===== wdpc_link_if.sv
`timescale 1ns/1ps
interface wdpc_link_if;
  import wdpc_pkg::*;

  // ****************************************************
  // core to device: one-cycle instruction pulses
  // ****************************************************
  logic             clear_watchdog_instruction;
  logic             timer_write;
  logic             option_write;
  logic [OPT_W-1:0] option_data;
  logic             sleep_instruction;

  // ****************************************************
  // device to core: levels
  // ****************************************************
  logic             device_reset;
  logic             timeout_flag_n;
  logic             powerdown_flag_n;
  logic             sleep_active;

  modport core (
    output clear_watchdog_instruction,
    output timer_write,
    output option_write,
    output option_data,
    output sleep_instruction,
    input  device_reset,
    input  timeout_flag_n,
    input  powerdown_flag_n,
    input  sleep_active
  );

  modport dev (
    input  clear_watchdog_instruction,
    input  timer_write,
    input  option_write,
    input  option_data,
    input  sleep_instruction,
    output device_reset,
    output timeout_flag_n,
    output powerdown_flag_n,
    output sleep_active
  );

endinterface

// ===== wdpc_core.sv
`timescale 1ns/1ps
module wdpc_core (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    srst,
  // link to the device
  wdpc_link_if.core                    link,
  // user command port
  input  wire logic                    cmd_valid,
  input  wire wdpc_pkg::wdpc_cmd_type  cmd_kind,
  input  wire logic [wdpc_pkg::OPT_W-1:0] cmd_option,
  output logic                         cmd_ready,
  // status
  output logic                         core_in_reset,
  output logic                         core_sleeping,
  output logic                         core_timeout_seen_n
);
  import wdpc_pkg::*;

  // ****************************************************
  // state and held data
  // ****************************************************
  wdpc_core_state_type state;
  wdpc_core_state_type next_state;
  logic [OPT_W-1:0]    data_q;
  logic [OPT_W-1:0]    final_q;
  logic                cur_psa;
  logic                need_step;

  // routing of an accepted command
  wire accept    = cmd_valid & cmd_ready;
  wire new_psa   = cmd_option[OPT_PSA_BIT];
  wire to_wdt    = new_psa & ~cur_psa;
  wire to_timer  = ~new_psa & cur_psa;
  wire low_ratio = cmd_option[OPT_PS_LSB +: PS_W] <= PS_STEP_MAX;
  wire [OPT_W-1:0] step_value = {cmd_option[OPT_W-1:OPT_PSA_BIT], PS_ALL_ONES};

  // nothing is issued while the device holds reset or sleeps
  assign cmd_ready = (state == ST_IDLE) & ~link.device_reset & ~link.sleep_active;

  // instruction pulses decoded from one-hot state flops
  assign link.clear_watchdog_instruction = (state == ST_CLR) | (state == ST_W_CLR) |
                                           (state == ST_W_CLR2) | (state == ST_T_CLR);
  assign link.timer_write       = (state == ST_TMR) | (state == ST_W_TMR);
  assign link.option_write      = (state == ST_OPT) | (state == ST_W_INT);
  assign link.sleep_instruction = (state == ST_SLP);
  assign link.option_data       = data_q;

  assign core_in_reset       = link.device_reset;
  assign core_sleeping       = link.sleep_active;
  assign core_timeout_seen_n = link.timeout_flag_n;

  // sequencing of the prescaler hand-over
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (accept) begin
          unique case (cmd_kind)
            CMD_CLEAR_WATCHDOG: next_state = ST_CLR;
            CMD_TIMER_WRITE:    next_state = ST_TMR;
            CMD_SLEEP:          next_state = ST_SLP;
            CMD_OPTION_WRITE: begin
              if (to_wdt) begin
                next_state = ST_W_CLR;
              end else if (to_timer) begin
                next_state = ST_T_CLR;
              end else begin
                next_state = ST_OPT;
              end
            end
          endcase
        end
      end
      ST_W_CLR:  next_state = ST_W_TMR;
      ST_W_TMR:  next_state = need_step ? ST_W_INT : ST_OPT;
      ST_W_INT:  next_state = ST_W_CLR2;
      ST_W_CLR2: next_state = ST_OPT;
      ST_T_CLR:  next_state = ST_OPT;
      ST_CLR, ST_TMR, ST_OPT, ST_SLP: next_state = ST_IDLE;
      default:   next_state = ST_IDLE;
    endcase
  end

  // state register; a device reset aborts any sequence
  always_ff @(posedge clk) begin
    if (srst | link.device_reset) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // option data: intermediate value first when a step is needed
  always_ff @(posedge clk) begin
    if (srst) begin
      data_q    <= OPTION_RESET;
      final_q   <= OPTION_RESET;
      need_step <= 1'b0;
    end else if (accept) begin
      need_step <= to_wdt & low_ratio;
      final_q   <= cmd_option;
      data_q    <= (to_wdt & low_ratio) ? step_value : cmd_option;
    end else if (state == ST_W_CLR2) begin
      data_q <= final_q;
    end
  end

  // mirror of the assign bit; the device restores it on reset
  always_ff @(posedge clk) begin
    if (srst | link.device_reset) begin
      cur_psa <= OPTION_RESET[OPT_PSA_BIT];
    end else if (state == ST_OPT) begin
      cur_psa <= data_q[OPT_PSA_BIT];
    end
  end

endmodule

// ===== wdpc_device.sv
// Functional notes
// - to watchdog: clear, timer write, then option
// - intermediate all-ones step only for ratio 000/001
// - to timer: clear first, then option assign 0
// - timer switch sequence even with watchdog disabled
// - clear watchdog before changing prescaler assignment
// - bits 1-0 select oscillator type
// - bit 2 enables watchdog; only off switch
// - nine protect bits 11-3, zero means protected
// - single variant: bit 3 protect, 11-4 zero
// - watchdog runs on own free-running tick
// - timeout resets device, also wakes from sleep
// - timeout clears the active-low timeout flag
// - reset timer holds chip in reset 18 ms
// - sleep ends only by external reset, timeout
// - assign bit 3 gives prescaler to one user
// - timer write (timer side) or clear/sleep (watchdog side) clears prescaler
// - 18 ms base, extended up to 1:128
`timescale 1ns/1ps
module wdpc_device #(
  parameter int unsigned WDT_CYCLES    = wdpc_pkg::WDT_BASE_CYCLES,
  parameter int unsigned DRT_CYCLES    = wdpc_pkg::DRT_CYCLES,
  parameter bit          MULTI_PROTECT = 1'b1
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        srst,
  // link to the core
  wdpc_link_if.dev                         link,
  // external pins
  input  wire logic                        ext_reset_n,
  input  wire logic [wdpc_pkg::CFG_W-1:0]  config_pins,
  // configuration view
  output logic [wdpc_pkg::CFG_W-1:0]       config_word,
  output wdpc_pkg::wdpc_osc_type           oscillator_select_field,
  output logic                             watchdog_enable_fuse,
  output logic                             code_protect_on,
  // timer side of the prescaler
  output logic                             timer_prescaled_tick,
  output logic                             timer_source_sel,
  output logic                             timer_edge_sel,
  // events
  output logic                             watchdog_timeout
);
  import wdpc_pkg::*;

  localparam int unsigned WDT_W = $clog2(WDT_CYCLES);
  localparam int unsigned DRT_W = $clog2(DRT_CYCLES);
  localparam logic [WDT_W-1:0] WDT_LAST = WDT_W'(WDT_CYCLES - 1);
  localparam logic [DRT_W-1:0] DRT_LAST = DRT_W'(DRT_CYCLES - 1);

  // ****************************************************
  // configuration word
  // ****************************************************
  logic [CFG_W-1:0] cfg;

  // unimplemented bits are masked so they read as zero
  wire [CFG_W-1:0] cfg_in = MULTI_PROTECT ? config_pins
                                          : (config_pins & CFG_SINGLE_MASK);

  // sampled only while srst is high; software has no write path
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg <= cfg_in;
    end
  end

  assign config_word             = cfg;
  assign oscillator_select_field = wdpc_osc_type'(cfg[CFG_OSC_LSB +: 2]);
  assign watchdog_enable_fuse    = cfg[CFG_WDT_EN_BIT];
  // any programmed protect bit turns protection on
  assign code_protect_on = MULTI_PROTECT ? ~&cfg[CFG_CP_MSB:CFG_CP_LSB]
                                         : ~cfg[CFG_CP_LSB];

  // ****************************************************
  // reset hold timer
  // ****************************************************
  logic             hold;
  logic [DRT_W-1:0] drt_cnt;
  logic             wdt_fire;

  wire ext_reset   = ~ext_reset_n;
  wire reset_event = ext_reset | wdt_fire;

  // any reset source restarts the full hold time
  always_ff @(posedge clk) begin
    if (srst | reset_event) begin
      hold    <= 1'b1;
      drt_cnt <= '0;
    end else if (hold) begin
      if (drt_cnt == DRT_LAST) begin
        hold <= 1'b0;
      end else begin
        drt_cnt <= drt_cnt + 1'b1;
      end
    end
  end

  assign link.device_reset = hold;

  // ****************************************************
  // option setting
  // ****************************************************
  logic [OPT_W-1:0] option;

  // every reset restores all ones, which gives the prescaler to the watchdog
  always_ff @(posedge clk) begin
    if (srst | hold) begin
      option <= OPTION_RESET;
    end else if (link.option_write) begin
      option <= link.option_data;
    end
  end

  wire            prescaler_assign_bit = option[OPT_PSA_BIT];
  wire [PS_W-1:0] ps  = option[OPT_PS_LSB +: PS_W];
  assign timer_source_sel = option[OPT_SRC_BIT];
  assign timer_edge_sel   = option[OPT_EDGE_BIT];

  // ****************************************************
  // sleep state
  // ****************************************************
  logic sleep_q;

  // entered by the sleep instruction, left only by a reset source
  always_ff @(posedge clk) begin
    if (srst | reset_event) begin
      sleep_q <= 1'b0;
    end else if (link.sleep_instruction & ~hold) begin
      sleep_q <= 1'b1;
    end
  end

  assign link.sleep_active = sleep_q;

  // ****************************************************
  // watchdog base divider
  // ****************************************************
  logic [WDT_W-1:0] base;

  // clear and sleep both restart the count; hold covers wake-up
  wire cmd_clr   = link.clear_watchdog_instruction & ~hold;
  wire cmd_sleep = link.sleep_instruction & ~hold;
  wire cmd_tmr   = link.timer_write & ~hold;
  wire wdt_clr   = cmd_clr | cmd_sleep | hold;
  wire wdt_run   = cfg[CFG_WDT_EN_BIT] & ~wdt_clr;
  // divider is not gated by sleep: it stands for the private oscillator
  wire base_wrap = wdt_run & (base == WDT_LAST);

  always_ff @(posedge clk) begin
    if (srst | ~wdt_run | base_wrap) begin
      base <= '0;
    end else begin
      base <= base + 1'b1;
    end
  end

  // ****************************************************
  // shared prescaler
  // ****************************************************
  logic [PRESC_W-1:0] presc;

  // watchdog ratios 1..128, timer ratios 2..256
  wire [PRESC_W-1:0] wdt_last = PRESC_W'((9'h001 << ps) - 9'h001);
  wire [PRESC_W-1:0] tmr_last = PRESC_W'((9'h002 << ps) - 9'h001);
  wire presc_clr  = hold | (prescaler_assign_bit ? (cmd_clr | cmd_sleep) : cmd_tmr);
  // the timer side steps once per instruction cycle, one per clk here
  wire presc_step = prescaler_assign_bit ? base_wrap : 1'b1;
  wire presc_last = presc == (prescaler_assign_bit ? wdt_last : tmr_last);

  always_ff @(posedge clk) begin
    if (srst | presc_clr | (presc_step & presc_last)) begin
      presc <= '0;
    end else if (presc_step) begin
      presc <= presc + 1'b1;
    end
  end

  // without the prescaler every base period times out
  assign wdt_fire = base_wrap & (~prescaler_assign_bit | presc_last);

  // registered event outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      watchdog_timeout     <= 1'b0;
      timer_prescaled_tick <= 1'b0;
    end else begin
      watchdog_timeout     <= wdt_fire;
      timer_prescaled_tick <= ~prescaler_assign_bit & ~presc_clr & presc_last;
    end
  end

  // ****************************************************
  // status flags
  // ****************************************************
  logic to_n;
  logic pd_n;

  // a clear or sleep wins over a timeout in the same cycle by blocking it
  always_ff @(posedge clk) begin
    if (srst) begin
      to_n <= 1'b1;
    end else if (wdt_fire) begin
      to_n <= 1'b0;
    end else if (cmd_clr | cmd_sleep) begin
      to_n <= 1'b1;
    end
  end

  // power-down flag: set at power-up and by clear, dropped by sleep
  always_ff @(posedge clk) begin
    if (srst) begin
      pd_n <= 1'b1;
    end else if (cmd_sleep) begin
      pd_n <= 1'b0;
    end else if (cmd_clr) begin
      pd_n <= 1'b1;
    end
  end

  assign link.timeout_flag_n   = to_n;
  assign link.powerdown_flag_n = pd_n;

endmodule

// ===== wdpc_link_sva.sv
`timescale 1ns/1ps
module wdpc_link_sva (
  // clock and reset
  input wire logic                          clk,
  input wire logic                          srst,
  // core to device
  input wire logic                          clear_watchdog_instruction,
  input wire logic                          timer_write,
  input wire logic                          option_write,
  input wire logic [wdpc_pkg::OPT_W-1:0]    option_data,
  input wire logic                          sleep_instruction,
  // device to core
  input wire logic                          device_reset,
  input wire logic                          timeout_flag_n,
  input wire logic                          powerdown_flag_n,
  input wire logic                          sleep_active
);
  import wdpc_pkg::*;

  // ****************************************************
  // helper logic
  // ****************************************************
  logic assign_q;

  // mirror of the assign bit; any device reset restores the option to all ones
  always_ff @(posedge clk) begin
    if (srst || device_reset) begin
      assign_q <= 1'b1;
    end else if (option_write) begin
      assign_q <= option_data[OPT_PSA_BIT];
    end
  end

  // ****************************************************
  // assertions
  // ****************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_SRST_HOLD: assert property ($fell(srst) |-> device_reset [*8])
    else $error("reset hold too short after release");
  AST_HOLD_LEN: assert property (
    $rose(device_reset) |-> device_reset [*8] ##[1:3] !device_reset)
    else $error("reset hold length wrong");
  AST_QUIET_IN_RESET: assert property (
    device_reset |-> !(timer_write || option_write || sleep_instruction))
    else $error("core issued work while held in reset");
  AST_TO_FLAG: assert property (
    $fell(timeout_flag_n) |-> device_reset && !sleep_active)
    else $error("timeout flag fell without a device reset");
  AST_WAKE: assert property ($fell(sleep_active) |-> device_reset)
    else $error("sleep left without a reset");
  AST_SLEEP_IN: assert property (
    sleep_instruction && !device_reset |=> sleep_active || device_reset)
    else $error("sleep not entered");
  AST_TO_WDT: assert property (
    $past(clear_watchdog_instruction) && timer_write && !assign_q
    |=> option_write && option_data[OPT_PSA_BIT])
    else $error("option write missing after timer write");
  AST_STEP: assert property (
    $past(clear_watchdog_instruction) && timer_write && !assign_q
    |=> option_data[2:0] == PS_ALL_ONES || option_data[2:0] > PS_STEP_MAX)
    else $error("low ratio written without intermediate step");
  AST_TO_TMR: assert property (
    option_write && !option_data[OPT_PSA_BIT] && assign_q
    |-> $past(clear_watchdog_instruction))
    else $error("assign to timer without prior clear");

endmodule

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
  import wdpc_pkg::*;

  // ****************************************************
  // signals
  // ****************************************************
  logic               clk = 1'b0, srst = 1'b1, srst_b = 1'b1;
  logic               ext_reset_n_a = 1'b1, ext_reset_n_b = 1'b1, cmd_valid = 1'b0;
  wdpc_cmd_type       cmd_kind = CMD_CLEAR_WATCHDOG;
  logic [OPT_W-1:0]   cmd_option = 6'h00;
  logic [CFG_W-1:0]   cfg_a = 12'hffd, cfg_b = 12'hfe2, word_a, word_b;
  wdpc_osc_type       osc_a, osc_b;
  logic               cmd_ready, in_rst, sleeping, seen_n, fuse_a, fuse_b, cp_a, cp_b;
  logic               tick_a, tick_b, src_a, edge_a, wto_a, wto_b;
  int                 mismatches = 0, n_checks = 0;

  wdpc_link_if link_a ();
  wdpc_link_if link_b ();

  // 50 ns clock
  initial begin
    forever #25 clk = ~clk;
  end

  // ****************************************************
  // design ends and checker
  // ****************************************************
  wdpc_core u_wdpc_core (.clk(clk), .srst(srst), .link(link_a), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_option(cmd_option), .cmd_ready(cmd_ready),
    .core_in_reset(in_rst), .core_sleeping(sleeping), .core_timeout_seen_n(seen_n));
  // short counts keep every timeout within a few hundred cycles
  wdpc_device #(.WDT_CYCLES(64), .DRT_CYCLES(8)) u_wdpc_device (
    .clk(clk), .srst(srst), .link(link_a), .ext_reset_n(ext_reset_n_a), .config_pins(cfg_a),
    .config_word(word_a), .oscillator_select_field(osc_a), .watchdog_enable_fuse(fuse_a),
    .code_protect_on(cp_a), .timer_prescaled_tick(tick_a), .timer_source_sel(src_a),
    .timer_edge_sel(edge_a), .watchdog_timeout(wto_a));
  // second device: single-protect variant, link driven by the bench
  wdpc_device #(.WDT_CYCLES(64), .DRT_CYCLES(8), .MULTI_PROTECT(1'b0)) u_wdpc_device_b (
    .clk(clk), .srst(srst_b), .link(link_b), .ext_reset_n(ext_reset_n_b),
    .config_pins(cfg_b), .config_word(word_b), .oscillator_select_field(osc_b),
    .watchdog_enable_fuse(fuse_b), .code_protect_on(cp_b), .timer_prescaled_tick(tick_b),
    .timer_source_sel(), .timer_edge_sel(), .watchdog_timeout(wto_b));
  wdpc_link_sva u_wdpc_link_sva (.clk(clk), .srst(srst),
    .clear_watchdog_instruction(link_a.clear_watchdog_instruction),
    .timer_write(link_a.timer_write), .option_write(link_a.option_write),
    .option_data(link_a.option_data), .sleep_instruction(link_a.sleep_instruction),
    .device_reset(link_a.device_reset), .timeout_flag_n(link_a.timeout_flag_n),
    .powerdown_flag_n(link_a.powerdown_flag_n), .sleep_active(link_a.sleep_active));

  // ****************************************************
  // helpers
  // ****************************************************
  task automatic results();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic bail(input int n);
    mismatches++;
    $display("BAD t=%0t got=%h exp=%h", $time, n, 0);
    results();
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [CFG_W-1:0] got, input logic [CFG_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_range(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, lo);
    end
  endtask

  // sample one step after the edge so its updates have landed
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (cmd_ready !== 1'b1) begin
      tick();
      n++;
      if (n > 400) bail(n);
    end
  endtask

  // waits for ready, then drives the command for one clock edge only
  task automatic send_cmd(input wdpc_cmd_type k, input logic [OPT_W-1:0] o);
    wait_ready();
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_option <= o;
    @(posedge clk);
    cmd_valid <= 1'b0;
    tick();
  endtask

  task automatic wait_wto(input int lim, output int cyc, output int tks);
    cyc = 0;
    tks = 0;
    while (wto_a !== 1'b1) begin
      tick();
      cyc++;
      if (tick_a === 1'b1) tks++;
      if (cyc > lim) bail(cyc);
    end
  endtask

  task automatic pulse_b(input wdpc_cmd_type k, input logic [OPT_W-1:0] d);
    @(posedge clk);
    link_b.clear_watchdog_instruction <= (k == CMD_CLEAR_WATCHDOG);
    link_b.timer_write <= (k == CMD_TIMER_WRITE);
    link_b.option_write <= (k == CMD_OPTION_WRITE);
    link_b.sleep_instruction <= (k == CMD_SLEEP);
    link_b.option_data <= d;
    @(posedge clk);
    link_b.clear_watchdog_instruction <= 1'b0;
    link_b.timer_write <= 1'b0;
    link_b.option_write <= 1'b0;
    link_b.sleep_instruction <= 1'b0;
  endtask

  task automatic reset_b(input logic [CFG_W-1:0] cfg);
    int n;
    n = 0;
    @(posedge clk);
    cfg_b <= cfg;
    srst_b <= 1'b1;
    @(posedge clk);
    srst_b <= 1'b0;
    tick();
    while (link_b.device_reset !== 1'b0) begin
      tick();
      n++;
      if (n > 40) bail(n);
    end
  endtask

  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic s_config_a();
    chk_word(word_a, 12'hffd);
    chk_word({10'h000, osc_a}, 12'h001);
    chk_bit(fuse_a, 1'b1);
    chk_bit(cp_a, 1'b0);
    @(posedge clk);
    cfg_a <= 12'h000;
    tick();
    chk_word(word_a, 12'hffd);
    // mid-run external reset restarts the hold but keeps the timeout flag
    @(posedge clk);
    ext_reset_n_a <= 1'b0;
    @(posedge clk);
    ext_reset_n_a <= 1'b1;
    tick();
    chk_bit(in_rst, 1'b1);
    chk_bit(seen_n, 1'b1);
  endtask

  // ratios 1:1, 1:2 and 1:4 reached by the to-timer then to-watchdog sequences
  task automatic s_ratios();
    int c;
    int t;
    for (int r = 0; r < 3; r++) begin
      send_cmd(CMD_OPTION_WRITE, 6'h00);
      send_cmd(CMD_OPTION_WRITE, 6'h08 | 6'(r));
      send_cmd(CMD_CLEAR_WATCHDOG, 6'h00);
      wait_wto(800, c, t);
      chk_range(c, 64 << r, (64 << r) + 5);
      chk_range(t, 0, 0);
    end
  endtask

  task automatic s_timer_side();
    int c;
    int t;
    send_cmd(CMD_OPTION_WRITE, 6'h10);
    wait_ready();
    chk_bit(src_a, 1'b0);
    chk_bit(edge_a, 1'b1);
    // timer write restarts the timer-side prescaler, so the tick phase is fixed
    send_cmd(CMD_TIMER_WRITE, 6'h00);
    tick();
    chk_bit(tick_a, 1'b0);
    tick();
    chk_bit(tick_a, 1'b1);
    send_cmd(CMD_CLEAR_WATCHDOG, 6'h00);
    wait_wto(200, c, t);
    chk_range(c, 64, 69);
    chk_range(t, c / 2 - 2, c / 2 + 1);
    tick();
    chk_bit(link_a.timeout_flag_n, 1'b0);
    chk_bit(link_a.device_reset, 1'b1);
    chk_bit(seen_n, 1'b0);
    chk_bit(src_a, 1'b1);
  endtask

  // clears keep the watchdog quiet; sleep then ends only by timeout
  task automatic s_clear_sleep();
    int c;
    int t;
    int seen;
    seen = 0;
    send_cmd(CMD_OPTION_WRITE, 6'h00);
    send_cmd(CMD_OPTION_WRITE, 6'h01);
    send_cmd(CMD_OPTION_WRITE, 6'h09);
    for (int i = 0; i < 4; i++) begin
      repeat (100) begin
        tick();
        if (wto_a === 1'b1) seen++;
      end
      send_cmd(CMD_CLEAR_WATCHDOG, 6'h00);
    end
    chk_range(seen, 0, 0);
    send_cmd(CMD_SLEEP, 6'h00);
    tick();
    chk_bit(sleeping, 1'b1);
    chk_bit(link_a.powerdown_flag_n, 1'b0);
    wait_wto(300, c, t);
    chk_range(c, 122, 133);
    tick();
    chk_bit(link_a.sleep_active, 1'b0);
    chk_bit(link_a.timeout_flag_n, 1'b0);
  endtask

  task automatic s_variant_b();
    for (int k = 0; k < 4; k++) begin
      reset_b({8'hff, 1'(k), 1'b0, 2'(k)});
      chk_word(word_b, {8'h00, 1'(k), 1'b0, 2'(k)});
      chk_word({10'h000, osc_b}, 12'(k));
      chk_bit(cp_b, ~1'(k));
      chk_bit(fuse_b, 1'b0);
    end
  endtask

  // watchdog off: to-timer switch, no timeout, sleep left by external reset
  task automatic s_disabled_b();
    int t;
    int seen;
    t = 0;
    seen = 0;
    pulse_b(CMD_CLEAR_WATCHDOG, 6'h3f);
    pulse_b(CMD_OPTION_WRITE, 6'h00);
    repeat (40) begin
      tick();
      if (tick_b === 1'b1) t++;
    end
    chk_range(t, 19, 21);
    pulse_b(CMD_SLEEP, 6'h00);
    repeat (300) begin
      tick();
      if (wto_b === 1'b1 || link_b.sleep_active !== 1'b1) seen++;
    end
    chk_range(seen, 0, 0);
    @(posedge clk);
    ext_reset_n_b <= 1'b0;
    @(posedge clk);
    ext_reset_n_b <= 1'b1;
    tick();
    chk_bit(link_b.sleep_active, 1'b0);
    chk_bit(link_b.device_reset, 1'b1);
    chk_bit(link_b.timeout_flag_n, 1'b1);
  endtask

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    int n;
    n = 0;
    // bench stands in for the core on the second link
    link_b.clear_watchdog_instruction = 1'b0;
    link_b.timer_write = 1'b0;
    link_b.option_write = 1'b0;
    link_b.option_data = 6'h00;
    link_b.sleep_instruction = 1'b0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    srst_b <= 1'b0;
    tick();
    while (in_rst === 1'b1 && n < 40) begin
      tick();
      n++;
    end
    chk_range(n, 7, 9);
    s_config_a();
    s_timer_side();
    s_ratios();
    s_clear_sleep();
    s_variant_b();
    s_disabled_b();
    results();
  end

endmodule
